// [design/gss_pkg.sv]
package gss_pkg;
    // Frame geometry
    localparam int          FRAME_BITS   = 16;
    localparam int          ADDR_BITS    = 7;
    localparam int          DATA_BITS    = 16;
    localparam int          REG_COUNT    = 64;
    localparam logic [4:0]  BIT_CNT_RST  = 5'h00;
    localparam logic [4:0]  BIT_CNT_LAST = 5'h0F;
    // Request word fields: bit 15 write flag, 14:8 byte address, 7:0 write byte
    localparam int          WR_FLAG_POS  = 15;
    localparam int          ADDR_MSB     = 14;
    localparam int          ADDR_LSB     = 8;
    localparam logic [15:0] REG_RST_VAL  = 16'h0000;
    localparam logic [15:0] DOUT_IDLE    = 16'h0000;
    // Host-side timing limits, for reference
    localparam real         IDLE_GAP_US  = 9.0;
    localparam real         SCLK_MIN_MHZ = 0.01;
    localparam real         SCLK_MAX_MHZ = 2.5;
    localparam real         CLK_MHZ      = 125.0;
    localparam int          IDLE_GAP_CYC = int'(IDLE_GAP_US * CLK_MHZ);
    // FIFO shape
    localparam int          FIFO_WIDTH   = 16;
    localparam int          FIFO_DEPTH   = 16;
endpackage

// [design/gss_fifo.sv]
`timescale 1ns/1ns
module gss_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0]   count;
    } gss_fifo_st_t;

    gss_fifo_st_t     st_ff;
    gss_fifo_st_t     nxt_st;
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic             push;
    logic             pop;

    // Handshakes and read data
    assign in_ready_o  = (st_ff.count != (AW+1)'(DEPTH));
    assign out_valid_o = (st_ff.count != '0);
    assign out_data_o  = mem_ff[st_ff.rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Pointer and count update
    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.wr_ptr = st_ff.wr_ptr + 1'b1;
        end
        if (pop) begin
            nxt_st.rd_ptr = st_ff.rd_ptr + 1'b1;
        end
        nxt_st.count = st_ff.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_ff[st_ff.wr_ptr] <= in_data_i;
        end
    end
endmodule

// [design/gss_spi_slave.sv]
// Functional notes
// - Output shifts on each falling clock edge after the first
// - Input sampled on each rising clock edge
// - Select active low gates all serial activity
// - MSB driven immediately when select falls
// - Output released while select high
// - Mode 3, clock idles high, MSB first
// - Read reply comes in following frame
// - Reply only after read request frame
// - Each register has two byte addresses
`timescale 1ns/1ns
module gss_spi_slave
    import gss_pkg::*;
(
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_b_i,
    input  wire logic                  sclk_i,
    input  wire logic                  cs_b_i,
    input  wire logic                  din_i,
    output logic                       dout_o,
    output logic                       dout_oe_o,
    // Register bank load port from the sensor side
    input  wire logic                  ld_valid_i,
    input  wire logic [ADDR_BITS-2:0]  ld_index_i,
    input  wire logic [DATA_BITS-1:0]  ld_data_i,
    // Received write frames, whole 16-bit words, streamed through the FIFO
    output logic                       wr_valid_o,
    input  wire logic                  wr_ready_i,
    output logic [FIFO_WIDTH-1:0]      wr_data_o,
    output logic                       busy_o
);
    typedef enum logic [0:0] {GSS_IDLE, GSS_XFER} gss_state_t;

    typedef struct packed {
        logic [1:0]           sclk_sync;
        logic [1:0]           cs_sync;
        logic [1:0]           din_sync;
        logic                 sclk_prev;
        logic                 cs_prev;
        gss_state_t           state;
        logic [4:0]           bit_cnt;
        logic [15:0]          rx_shift;
        logic [15:0]          tx_shift;
        logic [15:0]          tx_next;
        logic                 reply_ok;
        logic                 dout;
        logic                 dout_oe;
    } gss_st_t;

    gss_st_t               st_ff;
    gss_st_t               nxt_st;
    logic [DATA_BITS-1:0]  regs_ff [REG_COUNT];
    logic                  sclk_rise;
    logic                  sclk_fall;
    logic                  cs_fall;
    logic                  frame_done;
    logic [15:0]           rx_word;
    logic                  fifo_in_valid;
    logic                  fifo_in_ready;

    // Register read by byte address, both byte addresses return the whole word
    function automatic logic [15:0] reg_read(input logic [ADDR_BITS-1:0] addr);
        logic [15:0] word;
        word = regs_ff[addr[ADDR_BITS-1:1]];
        reg_read = word;
    endfunction

    // Edge detection on synchronised pins
    assign sclk_rise  = st_ff.sclk_sync[1] && !st_ff.sclk_prev;
    assign sclk_fall  = !st_ff.sclk_sync[1] && st_ff.sclk_prev;
    assign cs_fall    = !st_ff.cs_sync[1] && st_ff.cs_prev;
    assign rx_word    = {st_ff.rx_shift[14:0], st_ff.din_sync[1]};
    assign frame_done = (st_ff.state == GSS_XFER) && sclk_rise
                        && (st_ff.bit_cnt == BIT_CNT_LAST);
    assign fifo_in_valid = frame_done && rx_word[WR_FLAG_POS];

    always_comb begin
        nxt_st           = st_ff;
        nxt_st.sclk_sync = {st_ff.sclk_sync[0], sclk_i};
        nxt_st.cs_sync   = {st_ff.cs_sync[0], cs_b_i};
        nxt_st.din_sync  = {st_ff.din_sync[0], din_i};
        nxt_st.sclk_prev = st_ff.sclk_sync[1];
        nxt_st.cs_prev   = st_ff.cs_sync[1];
        unique case (st_ff.state)
            GSS_IDLE: begin
                if (cs_fall) begin
                    nxt_st.state   = GSS_XFER;
                    nxt_st.bit_cnt = BIT_CNT_RST;
                    nxt_st.dout_oe = 1'b1;
                    // Reply only if the previous frame completed as a read
                    nxt_st.reply_ok = 1'b0;
                    nxt_st.dout    = st_ff.reply_ok && st_ff.tx_next[15];
                    nxt_st.tx_shift = st_ff.reply_ok ? {st_ff.tx_next[14:0], 1'b0}
                                                     : DOUT_IDLE;
                end
            end
            GSS_XFER: begin
                if (st_ff.cs_sync[1]) begin
                    nxt_st.state   = GSS_IDLE;
                    nxt_st.dout_oe = 1'b0;
                end else begin
                    if (sclk_rise) begin
                        nxt_st.rx_shift = rx_word;
                        nxt_st.bit_cnt  = st_ff.bit_cnt + 5'h01;
                    end
                    if (sclk_fall && st_ff.bit_cnt != BIT_CNT_RST) begin
                        nxt_st.dout     = st_ff.tx_shift[15];
                        nxt_st.tx_shift = {st_ff.tx_shift[14:0], 1'b0};
                    end
                    if (frame_done) begin
                        // Read request prepares next frame's reply
                        nxt_st.reply_ok = !rx_word[WR_FLAG_POS];
                        nxt_st.tx_next  = rx_word[WR_FLAG_POS] ? DOUT_IDLE
                            : reg_read(rx_word[ADDR_MSB:ADDR_LSB]);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_ff           <= '0;
            st_ff.sclk_sync <= 2'b11;
            st_ff.cs_sync   <= 2'b11;
            st_ff.sclk_prev <= 1'b1;
            st_ff.cs_prev   <= 1'b1;
            st_ff.state     <= GSS_IDLE;
            st_ff.tx_next   <= DOUT_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Register bank: sensor loads words, write frames update one byte
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_ff[i] <= REG_RST_VAL;
            end
        end else begin
            if (ld_valid_i) begin
                regs_ff[ld_index_i] <= ld_data_i;
            end
            if (fifo_in_valid && fifo_in_ready) begin
                if (rx_word[ADDR_LSB]) begin
                    regs_ff[rx_word[ADDR_MSB:ADDR_LSB+1]][7:0] <= rx_word[7:0];
                end else begin
                    regs_ff[rx_word[ADDR_MSB:ADDR_LSB+1]][15:8] <= rx_word[7:0];
                end
            end
        end
    end

    // Write frames forwarded to the sensor side
    gss_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (rx_word),
        .out_valid_o (wr_valid_o),
        .out_ready_i (wr_ready_i),
        .out_data_o  (wr_data_o)
    );

    assign dout_o    = st_ff.dout;
    assign dout_oe_o = st_ff.dout_oe;
    assign busy_o    = (st_ff.state == GSS_XFER);
endmodule

// [testbench/gss_spi_slave_sva.sv]
`timescale 1ns/1ns
module gss_spi_chk (
    input wire logic        ref_clk_i,
    input wire logic        rst_b_i,
    input wire logic        sclk_i,
    input wire logic        cs_b_i,
    input wire logic        dout_o,
    input wire logic        dout_oe_o,
    input wire logic        wr_valid_o,
    input wire logic        wr_ready_i,
    input wire logic [15:0] wr_data_o,
    input wire logic        busy_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    // Output enable follows select
    chk_oe_rise: assert property ($fell(cs_b_i) |-> ##[1:5] dout_oe_o)
        else $error("oe late");
    chk_oe_drop: assert property ($rose(cs_b_i) |-> ##[1:5] !dout_oe_o)
        else $error("oe stuck");
    chk_oe_idle: assert property (cs_b_i [*6] |-> !dout_oe_o)
        else $error("oe idle");
    chk_oe_cause: assert property ($rose(dout_oe_o) |-> !cs_b_i && !$past(cs_b_i, 2))
        else $error("oe unselected");
    chk_busy_frame: assert property ($fell(cs_b_i) |-> ##[1:6] busy_o)
        else $error("no busy");
    // Output moves only after a falling clock or a falling select
    chk_dout_hold: assert property (
        (!cs_b_i && sclk_i && dout_oe_o) [*6] |-> $stable(dout_o)) else $error("dout moved");
    // Received write words
    chk_wr_flag: assert property (wr_valid_o |-> wr_data_o[15])
        else $error("bad write word");
    chk_wr_hold: assert property (
        wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_data_o)) else $error("word lost");
    cover property ($fell(cs_b_i));
    cover property (wr_valid_o && wr_ready_i);
    cover property ($rose(dout_oe_o));
endmodule
bind gss_spi_slave gss_spi_chk u_chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .sclk_i(sclk_i), .cs_b_i(cs_b_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
    .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_data_o(wr_data_o), .busy_o(busy_o));

// [testbench/gss_host_model.sv]
`timescale 1ns/1ns
module gss_host_model (
    output logic      sclk_o,
    output logic      cs_b_o,
    output logic      din_o,
    input  wire logic miso_i
);
    // Idle levels, clock high between frames
    initial begin
        sclk_o = 1'b1;
        cs_b_o = 1'b1;
        din_o  = 1'b0;
    end
    // One 16-bit frame, MSB first, 160 ns clock
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        #3;
        cs_b_o = 1'b0;
        #80;
        for (int i = 15; i >= 0; i--) begin
            sclk_o = 1'b0;
            din_o  = tx[i];
            #80;
            sclk_o = 1'b1;
            rx[i]  = miso_i;
            #80;
        end
        #80; // Hold select past last edge
        cs_b_o = 1'b1;
        din_o  = ~din_o;
        #9005; // Idle gap; frame length stays a whole clock count
    endtask
    // Frame cut after five clocks, then the usual idle gap
    task automatic cut();
        #3;
        cs_b_o = 1'b0;
        #80;
        repeat (5) begin
            sclk_o = 1'b0;
            din_o  = 1'b1;
            #80;
            sclk_o = 1'b1;
            #80;
        end
        #80;
        cs_b_o = 1'b1;
        #9005; // Idle gap
    endtask
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ns
module tb_top
    import gss_pkg::*;
;
    logic                 ref_clk_i  = 1'b0;
    logic                 rst_b_i    = 1'b0;
    logic                 ld_valid_i = 1'b0;
    logic [ADDR_BITS-2:0] ld_index_i = '0;
    logic [15:0]          ld_data_i  = '0;
    logic                 wr_ready_i = 1'b0;
    logic                 sclk, cs_b, din, dout_o, dout_oe_o, wr_valid_o, busy_o;
    logic [15:0]          wr_data_o, rx;
    int                   err_count  = 0, n_compared = 0, cyc = 0;
    logic [15:0]          rows [4]   = '{16'hA5C3, 16'h0001, 16'hFFFF, 16'h8000};
    wire                  miso       = dout_oe_o ? dout_o : 1'bz;

    gss_spi_slave u_gss_spi_slave (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk),
        .cs_b_i(cs_b), .din_i(din), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
        .ld_valid_i(ld_valid_i), .ld_index_i(ld_index_i), .ld_data_i(ld_data_i),
        .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_data_o(wr_data_o),
        .busy_o(busy_o));
    gss_host_model u_gss_host_model (.sclk_o(sclk), .cs_b_o(cs_b), .din_o(din), .miso_i(miso));

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude();
        if (err_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Clock and hang guard
    initial forever #4 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            conclude();
        end
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        chk("idle_oe", dout_oe_o, 16'h0000);
        foreach (rows[i]) begin
            ld_valid_i <= 1'b1;
            ld_index_i <= 6'(5 * i);
            ld_data_i  <= rows[i];
            @(posedge ref_clk_i);
        end
        ld_valid_i <= 1'b0;
        // Read rows, odd ones by lower byte address; reply arrives one frame late
        for (int i = 0; i <= 4; i++) begin
            u_gss_host_model.xfer(i < 4 ? {1'b0, 6'(5 * i), 1'(i), 8'h00} : 16'h0000, rx);
            chk("reply", rx, i == 0 ? 16'h0000 : rows[i-1]);
        end
        // Write frames while the consumer stalls, one more than fits
        for (int i = 0; i <= FIFO_DEPTH; i++)
            u_gss_host_model.xfer({1'b1, 7'(i), 8'h50 + 8'(i)}, rx);
        u_gss_host_model.xfer(16'h0000, rx);
        chk("after_write", rx, 16'h0000);
        u_gss_host_model.xfer(16'h1000, rx);
        chk("byte_lanes", rx, 16'h5051);
        // Word behind the refused surplus write is untouched
        u_gss_host_model.xfer(16'h0A00, rx);
        chk("surplus_word", rx, REG_RST_VAL);
        // Drain in order; the surplus frame was refused
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            @(posedge ref_clk_i);
            chk("wr_head", {wr_valid_o, wr_data_o[14:0]}, {1'b1, 7'(i), 8'h50 + 8'(i)});
            wr_ready_i <= 1'b1;
            @(posedge ref_clk_i);
            wr_ready_i <= 1'b0;
        end
        @(posedge ref_clk_i);
        chk("wr_empty", wr_valid_o, 16'h0000);
        // Cut frame: pending reply dropped, next frame framed afresh
        u_gss_host_model.cut();
        u_gss_host_model.xfer(16'h0000, rx);
        chk("cut_reply", rx, 16'h0000);
        u_gss_host_model.xfer(16'h0A00, rx);
        chk("cut_frame", rx, 16'h5051);
        // Reset mid-run clears the pending reply and the register bank
        @(posedge ref_clk_i);
        rst_b_i <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        chk("reset_busy", busy_o, 16'h0000);
        u_gss_host_model.xfer(16'h0A00, rx);
        chk("reset_reply", rx, 16'h0000);
        u_gss_host_model.xfer(16'h0000, rx);
        chk("reset_regs", rx, REG_RST_VAL);
        conclude();
    end
endmodule
